// file: src/tofr_result_bank.sv
// Flight-time converter core: measurement sequence and result registers.
// Assumes asynchronous pins from the host and the analog front end.
// Operation
// - Time results: 23-bit value, parity bit 23.
// - Clock count: 16-bit count, own address.
// - Clock count bits 22..16 read zero.
// - First calibration: 23-bit value with parity.
// - Second calibration at next address, parity.
// - Results read-only, all zero after reset.
// - Start command emits trigger pulse to front end.
// - START pulse starts the interval counters.
// - STOP pulse stops the counter.
// - Calibrate, then publish counter value.
`timescale 1ns/1ps
module tofr_result_bank #(
  parameter int TIMEOUT = tofr_pkg::TIMEOUT_CYCLES,
  parameter int CAL2_COUNT = tofr_pkg::CAL2_PERIODS
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic reset_n,
  // Serial register port.
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  output logic spi_miso,
  output logic spi_miso_oe,
  // Analog front end.
  output logic trigger_out,
  input wire logic start_pulse,
  input wire logic stop_pulse
);
  import tofr_pkg::*;

  logic [4:0] pins_sync;
  tofr_cmd_t cmd;
  logic cmd_valid, wr_valid;
  logic [23:0] wr_data;
  logic [23:0] rd_data, next_rd_data;

  // Bring every pin into the clock domain; cs_n resets to its idle high.
  tofr_sync #(.WIDTH(5), .RESET_VALUE(PIN_SYNC_RESET)) u_sync (
    .clock(clock),
    .reset_n(reset_n),
    .async_in({spi_sclk, spi_cs_n, spi_mosi, start_pulse, stop_pulse}),
    .sync_out(pins_sync)
  );

  tofr_spi_slave u_spi (
    .clock(clock),
    .reset_n(reset_n),
    .sclk(pins_sync[4]),
    .cs_n(pins_sync[3]),
    .mosi(pins_sync[2]),
    .miso(spi_miso),
    .miso_oe(spi_miso_oe),
    .cmd(cmd),
    .cmd_valid(cmd_valid),
    .rd_data(rd_data),
    .wr_data(wr_data),
    .wr_valid(wr_valid)
  );

  tofr_state_t state, next_state;
  logic start_d, stop_d, next_start_d, next_stop_d;
  logic start_rise, stop_rise, start_cmd;
  logic [3:0] trig_cnt, next_trig_cnt;
  logic [5:0] fine_cnt, next_fine_cnt;
  logic [15:0] coarse_cnt, next_coarse_cnt;
  logic [22:0] total_cnt, next_total_cnt;
  logic [31:0] wait_cnt, next_wait_cnt;
  logic [22:0] cal_cnt, next_cal_cnt;
  logic [22:0] cal1_cap, next_cal1_cap, cal2_cap, next_cal2_cap;
  logic [5:0] fine_cap, next_fine_cap;
  logic [15:0] coarse_cap, next_coarse_cap;
  logic [22:0] total_cap, next_total_cap;
  tofr_word_t fifth_time_result, next_fifth_time_result;
  tofr_word_t fifth_clock_count, next_fifth_clock_count;
  tofr_word_t sixth_time_result, next_sixth_time_result;
  tofr_word_t first_calibration_result, next_first_calibration_result;
  tofr_word_t second_calibration_result, next_second_calibration_result;
  logic timeout_flag, next_timeout_flag;
  logic done_flag, next_done_flag;
  logic done_clear;

  // Edges of the front-end pulses and the host start command.
  always_comb begin
    next_start_d = pins_sync[1];
    next_stop_d = pins_sync[0];
    start_rise = pins_sync[1] & ~start_d;
    stop_rise = pins_sync[0] & ~stop_d;
    start_cmd = wr_valid && cmd.addr == CONTROL_OFS
      && wr_data[CTRL_START_BIT];
    done_clear = cmd_valid && !cmd.write && cmd.addr == CONTROL_OFS;
  end

  // Measurement sequence and its counters.
  always_comb begin
    next_state = state;
    next_trig_cnt = trig_cnt;
    next_fine_cnt = fine_cnt;
    next_coarse_cnt = coarse_cnt;
    next_total_cnt = total_cnt;
    next_wait_cnt = wait_cnt;
    next_cal_cnt = cal_cnt;
    next_cal1_cap = cal1_cap;
    next_cal2_cap = cal2_cap;
    next_fine_cap = fine_cap;
    next_coarse_cap = coarse_cap;
    next_total_cap = total_cap;
    next_timeout_flag = timeout_flag;
    case (state)
      ST_IDLE: begin
        if (start_cmd) begin
          next_state = ST_TRIGGER;
          next_trig_cnt = 4'(TRIG_PULSE_CYCLES - 1);
          next_timeout_flag = 1'b0;
        end
      end
      ST_TRIGGER: begin
        if (trig_cnt == 4'h0) begin
          next_state = ST_WAIT_START;
          next_wait_cnt = 32'h00000000;
        end else begin
          next_trig_cnt = trig_cnt - 4'h1;
        end
      end
      ST_WAIT_START: begin
        next_wait_cnt = wait_cnt + 32'h00000001;
        if (start_rise) begin
          next_state = ST_COUNT;
          next_fine_cnt = 6'h00;
          next_coarse_cnt = 16'h0000;
          next_total_cnt = 23'h000000;
          next_wait_cnt = 32'h00000000;
        end else if (wait_cnt == 32'(TIMEOUT - 1)) begin
          next_state = ST_IDLE;
          next_timeout_flag = 1'b1;
        end
      end
      ST_COUNT: begin
        next_wait_cnt = wait_cnt + 32'h00000001;
        next_total_cnt = total_cnt + 23'h000001;
        if (fine_cnt == 6'(COARSE_PERIOD_CYCLES - 1)) begin
          next_fine_cnt = 6'h00;
          next_coarse_cnt = coarse_cnt + 16'h0001;
        end else begin
          next_fine_cnt = fine_cnt + 6'h01;
        end
        if (stop_rise) begin
          next_state = ST_CALIBRATE;
          next_fine_cap = fine_cnt;
          next_coarse_cap = coarse_cnt;
          next_total_cap = total_cnt;
          next_cal_cnt = 23'h000000;
        end else if (wait_cnt == 32'(TIMEOUT - 1)) begin
          next_state = ST_IDLE;
          next_timeout_flag = 1'b1;
        end
      end
      ST_CALIBRATE: begin
        // Time a short and a long run of reference periods.
        next_cal_cnt = cal_cnt + 23'h000001;
        if (cal_cnt == 23'(CAL1_PERIODS - 1)) begin
          next_cal1_cap = next_cal_cnt;
        end
        if (cal_cnt == 23'(CAL2_COUNT - 1)) begin
          next_cal2_cap = next_cal_cnt;
          next_state = ST_PUBLISH;
        end
      end
      ST_PUBLISH: begin
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // Result registers load only at publish; host writes never reach them.
  always_comb begin
    next_fifth_time_result = fifth_time_result;
    next_fifth_clock_count = fifth_clock_count;
    next_sixth_time_result = sixth_time_result;
    next_first_calibration_result = first_calibration_result;
    next_second_calibration_result = second_calibration_result;
    next_done_flag = done_flag & ~done_clear;
    if (state == ST_PUBLISH) begin
      next_done_flag = 1'b1;
      next_fifth_time_result = tofr_make_word({17'h00000, fine_cap});
      next_fifth_clock_count =
        tofr_make_word({7'h00, coarse_cap});
      next_sixth_time_result = tofr_make_word(total_cap);
      next_first_calibration_result = tofr_make_word(cal1_cap);
      next_second_calibration_result = tofr_make_word(cal2_cap);
    end
  end

  // Read multiplexer; unmapped offsets read zero.
  always_comb begin
    next_rd_data = 24'h000000;
    case (cmd.addr)
      CONTROL_OFS: begin
        next_rd_data[CTRL_BUSY_BIT] = state != ST_IDLE;
        next_rd_data[CTRL_TIMEOUT_BIT] = timeout_flag;
        next_rd_data[CTRL_DONE_BIT] = done_flag;
      end
      FIFTH_TIME_OFS: next_rd_data = fifth_time_result;
      FIFTH_CLOCK_COUNT_OFS: next_rd_data = fifth_clock_count;
      SIXTH_TIME_OFS: next_rd_data = sixth_time_result;
      FIRST_CAL_OFS: next_rd_data = first_calibration_result;
      SECOND_CAL_OFS: next_rd_data = second_calibration_result;
      default: next_rd_data = 24'h000000;
    endcase
  end

  // Register all state; every result word clears to zero.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state <= ST_IDLE;
      start_d <= 1'b0;
      stop_d <= 1'b0;
      trig_cnt <= 4'h0;
      fine_cnt <= 6'h00;
      coarse_cnt <= 16'h0000;
      total_cnt <= 23'h000000;
      wait_cnt <= 32'h00000000;
      cal_cnt <= 23'h000000;
      cal1_cap <= 23'h000000;
      cal2_cap <= 23'h000000;
      fine_cap <= 6'h00;
      coarse_cap <= 16'h0000;
      total_cap <= 23'h000000;
      fifth_time_result <= RESULT_RESET;
      fifth_clock_count <= RESULT_RESET;
      sixth_time_result <= RESULT_RESET;
      first_calibration_result <= RESULT_RESET;
      second_calibration_result <= RESULT_RESET;
      timeout_flag <= 1'b0;
      done_flag <= 1'b0;
      rd_data <= 24'h000000;
    end else begin
      state <= next_state;
      start_d <= next_start_d;
      stop_d <= next_stop_d;
      trig_cnt <= next_trig_cnt;
      fine_cnt <= next_fine_cnt;
      coarse_cnt <= next_coarse_cnt;
      total_cnt <= next_total_cnt;
      wait_cnt <= next_wait_cnt;
      cal_cnt <= next_cal_cnt;
      cal1_cap <= next_cal1_cap;
      cal2_cap <= next_cal2_cap;
      fine_cap <= next_fine_cap;
      coarse_cap <= next_coarse_cap;
      total_cap <= next_total_cap;
      fifth_time_result <= next_fifth_time_result;
      fifth_clock_count <= next_fifth_clock_count;
      sixth_time_result <= next_sixth_time_result;
      first_calibration_result <= next_first_calibration_result;
      second_calibration_result <= next_second_calibration_result;
      timeout_flag <= next_timeout_flag;
      done_flag <= next_done_flag;
      rd_data <= next_rd_data;
    end
  end

  // Trigger is high for the whole trigger phase.
  assign trigger_out = state == ST_TRIGGER;

  property p_time_parity;
    @(posedge clock) disable iff (!reset_n)
      sixth_time_result.parity == ^sixth_time_result.value
      && fifth_time_result.parity == ^fifth_time_result.value;
  endproperty
  a_time_parity: assert property (p_time_parity)
    else $error("time result parity wrong");

  property p_count_layout;
    @(posedge clock) disable iff (!reset_n)
      $rose(done_flag) |-> fifth_clock_count.value[15:0] == $past(coarse_cap)
      && fifth_clock_count.parity == ^fifth_clock_count.value;
  endproperty
  a_count_layout: assert property (p_count_layout)
    else $error("clock count not loaded from coarse count");

  property p_count_upper_zero;
    @(posedge clock) disable iff (!reset_n)
      fifth_clock_count.value[22:16] == 7'h00;
  endproperty
  a_count_upper_zero: assert property (p_count_upper_zero)
    else $error("clock count upper bits not zero");

  property p_cal1;
    @(posedge clock) disable iff (!reset_n)
      state == ST_PUBLISH |=> first_calibration_result.value == 23'(CAL1_PERIODS)
      && first_calibration_result.parity == ^first_calibration_result.value;
  endproperty
  a_cal1: assert property (p_cal1)
    else $error("first calibration word wrong");

  property p_cal2;
    @(posedge clock) disable iff (!reset_n)
      state == ST_PUBLISH |=> second_calibration_result.value == 23'(CAL2_COUNT)
      && second_calibration_result.parity == ^second_calibration_result.value;
  endproperty
  a_cal2: assert property (p_cal2)
    else $error("second calibration word wrong");

  property p_read_only;
    @(posedge clock) disable iff (!reset_n)
      state != ST_PUBLISH |=> $stable(sixth_time_result)
      && $stable(fifth_clock_count) && $stable(second_calibration_result);
  endproperty
  a_read_only: assert property (p_read_only)
    else $error("result changed outside publish");

  property p_trigger;
    @(posedge clock) disable iff (!reset_n)
      state == ST_IDLE && start_cmd |=> trigger_out [*5] ##1 !trigger_out;
  endproperty
  a_trigger: assert property (p_trigger)
    else $error("trigger pulse missing or wrong width");

  property p_start;
    @(posedge clock) disable iff (!reset_n)
      state == ST_WAIT_START && start_rise |=> state == ST_COUNT
      && total_cnt == 23'h000000;
  endproperty
  a_start: assert property (p_start)
    else $error("counters did not start");

  property p_stop;
    @(posedge clock) disable iff (!reset_n)
      state == ST_COUNT && stop_rise |=> state == ST_CALIBRATE
      && total_cap == $past(total_cnt);
  endproperty
  a_stop: assert property (p_stop)
    else $error("counter did not stop");

endmodule

// file: pkg/tofr_pkg.sv
// Shared constants and types of the flight-time result register bank.
// Assumes a single 125 MHz system clock; every user includes this package.
package tofr_pkg;

  // Register word layout.
  localparam int REG_W = 24;
  localparam int PARITY_BIT = 23;
  localparam int VALUE_MSB = 22;
  localparam int COUNT_MSB = 15;
  localparam int ADDR_W = 6;
  localparam logic [23:0] RESULT_RESET = 24'h000000;
  // Idle levels of the synchronised pins {sclk, cs_n, mosi, start, stop}.
  localparam logic [4:0] PIN_SYNC_RESET = 5'h08;

  // Register offsets.
  localparam logic [5:0] CONTROL_OFS = 6'h00;
  localparam logic [5:0] FIFTH_TIME_OFS = 6'h18;
  localparam logic [5:0] FIFTH_CLOCK_COUNT_OFS = 6'h19;
  localparam logic [5:0] SIXTH_TIME_OFS = 6'h1a;
  localparam logic [5:0] FIRST_CAL_OFS = 6'h1b;
  localparam logic [5:0] SECOND_CAL_OFS = 6'h1c;

  // Control register fields.
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_BUSY_BIT = 0;
  localparam int CTRL_TIMEOUT_BIT = 1;
  localparam int CTRL_DONE_BIT = 2;

  // Serial frame layout: one command byte, then one 24-bit word.
  localparam int CMD_BITS = 8;
  localparam int FRAME_BITS = 32;
  localparam int CMD_WRITE_BIT = 6;

  // Timing.
  localparam int CLOCK_NS = 8;
  localparam int TRIG_PULSE_NS = 40;
  localparam int TRIG_PULSE_CYCLES = (TRIG_PULSE_NS + CLOCK_NS - 1) / CLOCK_NS;
  localparam int COARSE_PERIOD_CYCLES = 64;
  localparam int CAL1_PERIODS = 1;
  localparam int CAL2_PERIODS = 10;
  localparam int TIMEOUT_NS = 1000000;
  localparam int TIMEOUT_CYCLES = TIMEOUT_NS / CLOCK_NS;

  // Decoded serial command.
  typedef struct packed {
    logic write;
    logic [5:0] addr;
  } tofr_cmd_t;

  // One result register word.
  typedef struct packed {
    logic parity;
    logic [22:0] value;
  } tofr_word_t;

  // Measurement sequence, one-hot.
  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_TRIGGER = 6'b000010,
    ST_WAIT_START = 6'b000100,
    ST_COUNT = 6'b001000,
    ST_CALIBRATE = 6'b010000,
    ST_PUBLISH = 6'b100000
  } tofr_state_t;

  // Builds a result word with even parity over the value bits.
  function automatic tofr_word_t tofr_make_word(input logic [22:0] value);
    tofr_word_t w;
    w.value = value;
    w.parity = ^value;
    return w;
  endfunction

endpackage

// file: src/tofr_sync.sv
// Two-flop synchroniser for a group of asynchronous pins.
// Assumes each bit is an independent level; no bus coherence is kept.
`timescale 1ns/1ps
module tofr_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic reset_n,
  // Pins and their synchronised copies.
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] next_stage1;
  logic [WIDTH-1:0] next_sync_out;

  // Next values: the first stage feeds only the second.
  always_comb begin
    next_stage1 = async_in;
    next_sync_out = stage1;
  end

  // Register both stages; each bit resets to its pin's idle level, so that
  // no false select or false edge shows after reset.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      stage1 <= RESET_VALUE;
      sync_out <= RESET_VALUE;
    end else begin
      stage1 <= next_stage1;
      sync_out <= next_sync_out;
    end
  end

endmodule

// file: src/tofr_spi_slave.sv
// Serial slave, mode 0, oversampled by the system clock.
// Assumes synchronised pins and a serial clock at most one eighth of clock.
`timescale 1ns/1ps
module tofr_spi_slave (
  // Clock and reset.
  input wire logic clock,
  input wire logic reset_n,
  // Synchronised serial pins.
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  output logic miso,
  output logic miso_oe,
  // Register side.
  output tofr_pkg::tofr_cmd_t cmd,
  output logic cmd_valid,
  input wire logic [23:0] rd_data,
  output logic [23:0] wr_data,
  output logic wr_valid
);
  import tofr_pkg::*;

  logic sclk_d, next_sclk_d;
  logic [5:0] bit_cnt, next_bit_cnt;
  logic [23:0] rx, next_rx;
  logic [23:0] tx, next_tx;
  logic load, next_load;
  tofr_cmd_t next_cmd;
  logic next_cmd_valid, next_wr_valid;
  logic [23:0] next_wr_data;
  logic rise, fall;
  logic [7:0] cmd_byte;

  // Shift on serial edges; the command byte fetches the read word.
  always_comb begin
    rise = sclk & ~sclk_d;
    fall = ~sclk & sclk_d;
    cmd_byte = {rx[6:0], mosi};
    next_sclk_d = sclk;
    next_bit_cnt = bit_cnt;
    next_rx = rx;
    next_tx = tx;
    next_cmd = cmd;
    next_cmd_valid = 1'b0;
    next_wr_valid = 1'b0;
    next_wr_data = wr_data;
    next_load = cmd_valid;
    if (load) begin
      next_tx = rd_data;
    end
    if (cs_n) begin
      next_bit_cnt = 6'h00;
    end else if (rise) begin
      next_rx = {rx[22:0], mosi};
      next_bit_cnt = bit_cnt + 6'h01;
      if (bit_cnt == 6'(CMD_BITS - 1)) begin
        next_cmd.write = cmd_byte[CMD_WRITE_BIT];
        next_cmd.addr = cmd_byte[5:0];
        next_cmd_valid = 1'b1;
      end
      if (bit_cnt == 6'(FRAME_BITS - 1) && cmd.write) begin
        next_wr_data = {rx[22:0], mosi};
        next_wr_valid = 1'b1;
      end
    end else if (fall && bit_cnt > 6'(CMD_BITS)) begin
      next_tx = {tx[22:0], 1'b0};
    end
  end

  // Register the slave state.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      sclk_d <= 1'b0;
      bit_cnt <= 6'h00;
      rx <= 24'h000000;
      tx <= 24'h000000;
      load <= 1'b0;
      cmd <= '0;
      cmd_valid <= 1'b0;
      wr_valid <= 1'b0;
      wr_data <= 24'h000000;
    end else begin
      sclk_d <= next_sclk_d;
      bit_cnt <= next_bit_cnt;
      rx <= next_rx;
      tx <= next_tx;
      load <= next_load;
      cmd <= next_cmd;
      cmd_valid <= next_cmd_valid;
      wr_valid <= next_wr_valid;
      wr_data <= next_wr_data;
    end
  end

  // Drive the data pin only while selected.
  assign miso = tx[23];
  assign miso_oe = ~cs_n;

endmodule

// file: testbench/tofr_afe_model.sv
// Behavioural front end that answers each trigger with a START and a STOP.
// Assumes the bench sets the gaps before it issues the start command.
`timescale 1ns/1ps
module tofr_afe_model (
  // Clock.
  input wire logic clock,
  // Settings from the bench.
  input wire logic respond,
  input wire logic [15:0] start_gap,
  input wire logic [15:0] stop_gap,
  // Front end pins.
  input wire logic trigger_out,
  output logic start_pulse,
  output logic stop_pulse
);
  initial begin
    start_pulse = 1'b0;
    stop_pulse = 1'b0;
  end

  // Fires START after the trigger, then STOP exactly stop_gap cycles later.
  // Pulses stay three cycles wide so the synchroniser always sees them.
  always begin
    @(posedge trigger_out);
    if (respond) begin
      repeat (start_gap) @(posedge clock);
      #1 start_pulse = 1'b1;
      repeat (3) @(posedge clock);
      #1 start_pulse = 1'b0;
      repeat (stop_gap - 16'd3) @(posedge clock);
      #1 stop_pulse = 1'b1;
      repeat (3) @(posedge clock);
      #1 stop_pulse = 1'b0;
    end
  end
endmodule

// file: testbench/tb.sv
// Self-checking bench of the result register bank, host side played here.
// Assumes the front end model and a serial clock of one sixteenth of clock.
`timescale 1ns/1ps
module tb;
  import tofr_pkg::*;
  localparam int TMO = 200;
  localparam int CAL2 = 10;
  localparam int HALF = 8;
  logic clock;
  logic reset_n;
  logic spi_sclk;
  logic spi_cs_n;
  logic spi_mosi;
  logic spi_miso;
  logic spi_miso_oe;
  logic trigger_out;
  logic start_pulse;
  logic stop_pulse;
  logic respond;
  logic [15:0] start_gap;
  logic [15:0] stop_gap;
  logic [31:0] seed;
  logic [23:0] rd;
  logic [23:0] exp_res [0:4];
  int failures = 0;
  int cmp_count = 0;
  int trig_run = 0;
  int trig_width = 0;
  int trig_count = 0;

  tofr_result_bank #(.TIMEOUT(TMO), .CAL2_COUNT(CAL2)) i_tofr_result_bank (
    .clock(clock), .reset_n(reset_n), .spi_sclk(spi_sclk),
    .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
    .spi_miso_oe(spi_miso_oe), .trigger_out(trigger_out),
    .start_pulse(start_pulse), .stop_pulse(stop_pulse));

  tofr_afe_model i_tofr_afe_model (
    .clock(clock), .respond(respond), .start_gap(start_gap),
    .stop_gap(stop_gap), .trigger_out(trigger_out),
    .start_pulse(start_pulse), .stop_pulse(stop_pulse));

  // Free-running system clock, 8 ns period.
  always #4 clock = ~clock;

  // Measures the width of every trigger pulse and counts them.
  always @(posedge clock) begin
    if (trigger_out === 1'b1) begin
      trig_run <= trig_run + 1;
    end else if (trig_run != 0) begin
      trig_width <= trig_run;
      trig_count <= trig_count + 1;
      trig_run <= 0;
    end
  end

  // Xorshift generator for repeatable random gaps and data.
  function automatic logic [31:0] next_rand(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction

  // Expected register word: even parity over the value bits.
  function automatic logic [23:0] exp_word(input logic [22:0] v);
    return {^v, v};
  endfunction

  // Compares one value and reports a mismatch at once.
  task automatic check(input logic [23:0] got, input logic [23:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One full serial frame, mode 0; miso is taken just before each rise of the 24 data bits.
  task automatic spi_frame(input logic [7:0] cmd, input logic [23:0] wdata,
                           output logic [23:0] rdata);
    logic [31:0] sh;
    sh = {cmd, wdata};
    rdata = '0;
    @(posedge clock);
    #1 spi_cs_n = 1'b0;
    for (int i = 31; i >= 0; i--) begin
      spi_mosi = sh[i];
      repeat (HALF) @(posedge clock);
      #1;
      if (i == 31) check({23'h0, spi_miso_oe}, 24'h000001);
      if (i < 24) rdata = {rdata[22:0], spi_miso};
      spi_sclk = 1'b1;
      repeat (HALF) @(posedge clock);
      #1 spi_sclk = 1'b0;
    end
    repeat (HALF) @(posedge clock);
    #1 spi_cs_n = 1'b1;
    spi_mosi = 1'b0;
    repeat (4) @(posedge clock);
    #1;
    check({23'h0, spi_miso_oe}, 24'h000000);
  endtask

  task automatic reg_read(input logic [5:0] addr, output logic [23:0] d);
    spi_frame({2'b00, addr}, 24'h000000, d);
  endtask

  task automatic reg_write(input logic [5:0] addr, input logic [23:0] d);
    logic [23:0] dummy;
    spi_frame({2'b01, addr}, d, dummy);
  endtask

  // Reads all five result words and compares them with the expectation.
  task automatic check_results();
    for (int k = 0; k < 5; k++) begin
      reg_read(FIFTH_TIME_OFS + 6'(k), rd);
      check(rd, exp_res[k]);
    end
  endtask

  // One measurement with a START gap sg and a START to STOP span of d.
  task automatic measure(input int sg, input int d);
    int n;
    start_gap = 16'(sg);
    stop_gap = 16'(d);
    respond = 1'b1;
    n = trig_count;
    reg_write(CONTROL_OFS, 24'h000001);
    repeat (sg + d + CAL2 + 20) @(posedge clock);
    #1;
    check(24'(trig_count - n), 24'h000001);
    check(24'(trig_width), 24'(TRIG_PULSE_CYCLES));
    reg_read(CONTROL_OFS, rd);
    check({21'h0, rd[2:0]}, 24'h000004);
    // The counters run from the cycle after START is seen until STOP is
    // seen, so they hold one less than the span between the pulses.
    exp_res[0] = exp_word(23'((d - 1) % COARSE_PERIOD_CYCLES));
    exp_res[1] = exp_word(23'((d - 1) / COARSE_PERIOD_CYCLES));
    exp_res[2] = exp_word(23'(d - 1));
    exp_res[3] = exp_word(23'(CAL1_PERIODS));
    exp_res[4] = exp_word(23'(CAL2));
    check_results();
    $display("test measure span %0d done", d);
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic stop_test();
    $display("comparisons=%0d mismatches=%0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Watchdog of 90000 cycles, about twice the 47000 the sequence needs.
  initial begin
    #720000;
    failures++;
    $display("watchdog expired");
    stop_test();
  end

  // Main sequence.
  initial begin
    int sg;
    int d;
    clock = 1'b0;
    reset_n = 1'b0;
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b0;
    respond = 1'b0;
    start_gap = 16'd10;
    stop_gap = 16'd20;
    seed = 32'h00000008;
    repeat (6) @(posedge clock);
    #1 reset_n = 1'b1;
    repeat (4) @(posedge clock);
    #1;
    for (int k = 0; k < 5; k++) exp_res[k] = RESULT_RESET;
    check_results();
    reg_read(6'h3f, rd);
    check(rd, 24'h000000);
    $display("test reset values done");
    measure(10, 63);
    measure(12, 64);
    measure(11, 4);
    measure(14, 150);
    for (int r = 0; r < 4; r++) begin
      seed = next_rand(seed);
      sg = 10 + int'(seed % 30);
      seed = next_rand(seed);
      d = 4 + int'(seed % 180);
      measure(sg, d);
    end
    for (int k = 0; k < 5; k++) begin
      seed = next_rand(seed);
      reg_write(FIFTH_TIME_OFS + 6'(k), seed[23:0]);
    end
    check_results();
    $display("test read-only writes done");
    respond = 1'b0;
    reg_write(CONTROL_OFS, 24'h000001);
    repeat (TMO + 50) @(posedge clock);
    #1;
    reg_read(CONTROL_OFS, rd);
    check({21'h0, rd[2:0]}, 24'h000002);
    check_results();
    $display("test missing start done");
    measure(10, 30);
    stop_test();
  end
endmodule
